/* dphy_lane_map.sv */
/*
 * lane role and wire polarity mapping with registered lane outputs.
 * assumes drive inputs come from logic on the same core clock.
 */
`timescale 1ns/1ps
module dphy_lane_map (
    input wire logic core_clk_in, // core clock
    input wire logic rstn_in, // async reset, active low
    input wire logic [3:0] lane_is_clk_in, // lane role, 1 = clock lane
    input wire logic [3:0] inv_p_in, // invert positive wire per lane
    input wire logic [3:0] inv_n_in, // invert negative wire per lane
    input wire dphy_seq_pkg::role_drive_s clk_drv_in, // clock lane drive
    input wire dphy_seq_pkg::role_drive_s data_drv_in, // data lane drive, byte unused
    input wire logic [31:0] data_word_in, // one byte per data lane by rank
    output dphy_seq_pkg::lanes_t lanes_out // registered lane drive
);
    dphy_seq_pkg::lanes_t state_ff;
    dphy_seq_pkg::lanes_t nxt_state;

    // number of data lanes below lane k picks its byte
    function automatic logic [1:0] data_rank(input logic [3:0] is_clk, input int k);
        logic [1:0] r;
        r = 2'h0;
        for (int i = 0; i < k; i++) begin
            if (!is_clk[i]) begin
                r = r + 2'h1;
            end
        end
        return r;
    endfunction : data_rank

    // role select then per-wire inversion
    always_comb begin
        dphy_seq_pkg::role_drive_s d;
        logic [7:0] b;
        d = '0;
        b = '0;
        nxt_state = state_ff;
        for (int k = 0; k < dphy_seq_pkg::LANES; k++) begin
            d = lane_is_clk_in[k] ? clk_drv_in : data_drv_in;
            b = lane_is_clk_in[k] ? clk_drv_in.hs_byte : data_word_in[data_rank(lane_is_clk_in, k)*8 +: 8];
            nxt_state[k].hs_en = d.hs_en;
            nxt_state[k].lp_p = d.lp_p ^ inv_p_in[k];
            nxt_state[k].lp_n = d.lp_n ^ inv_n_in[k];
            nxt_state[k].hs_p = b ^ {8{inv_p_in[k]}};
            nxt_state[k].hs_n = ~b ^ {8{inv_n_in[k]}};
        end
    end

    // lane output registers, idle LP-11
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            for (int k = 0; k < dphy_seq_pkg::LANES; k++) begin
                state_ff[k] <= {1'b1, 1'b1, 1'b0, 8'h00, 8'hff};
            end
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign lanes_out = state_ff;
endmodule : dphy_lane_map

/* dphy_rx_model.sv */
/*
 * receiver model: finds bursts on the rank-0 data lane from its sync byte alone.
 * assumes the lanes are sampled on the transmitter's own core clock.
 */
`timescale 1ns/1ps
module dphy_rx_model (
    input wire logic core_clk_in, // sampling clock
    input wire logic rstn_in, // async reset, active low
    input wire dphy_seq_pkg::lanes_t lanes_in, // lane drive seen
    input wire logic [3:0] lane_is_clk_in, // lane roles
    input wire logic [3:0] inv_p_in, // positive wire inversion
    output logic [7:0] bursts_out, // bursts found
    output logic [7:0] first_byte_out, // first payload byte of last burst
    output logic clk_drop_out // clock lane left high speed
);
    logic in_sync_ff;
    logic clk_up_ff;
    logic [1:0] d;
    logic [1:0] c;
    logic [7:0] b;
    // lowest data lane and lowest clock lane
    always_comb begin
        d = 2'h0;
        c = 2'h0;
        for (int k = 3; k >= 0; k--) begin
            if (lane_is_clk_in[k]) c = 2'(k);
            else d = 2'(k);
        end
        b = lanes_in[d].hs_p ^ {8{inv_p_in[d]}};
    end
    // burst start from data sync only, clock lane assumed always high speed
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            in_sync_ff <= 1'b0;
            clk_up_ff <= 1'b0;
            bursts_out <= 8'h00;
            first_byte_out <= 8'h00;
            clk_drop_out <= 1'b0;
        end else begin
            if (lanes_in[d].hs_en && b == dphy_seq_pkg::SYNC_BYTE) begin
                in_sync_ff <= 1'b1;
            end else if (in_sync_ff && lanes_in[d].hs_en) begin
                in_sync_ff <= 1'b0;
                bursts_out <= bursts_out + 8'h01;
                first_byte_out <= b;
            end
            clk_up_ff <= clk_up_ff | lanes_in[c].hs_en;
            if (clk_up_ff && !lanes_in[c].hs_en) clk_drop_out <= 1'b1;
        end
    end
endmodule : dphy_rx_model

/* dphy_seq_pkg.sv */
/*
 * constants, states and carrier types for the four-lane serial transmit sequencer.
 * assumes a 25 MHz core clock and the fastest nominal unit interval for the lane timing.
 */
// What this block does
// - four lanes, each one set individually as data lane or clock lane
// - either wire of every lane may be inverted by configuration
// - once enabled, clock lane toggles in high speed and never returns to low power
// - lane bit rate 150 to 600 Mbps, lane clock 75 to 300 MHz
// - clock runs at least 8 ns before a data lane leaves low power
// - clock lane holds LP-00 for 38 to 95 ns before HS-0
// - clock prepare plus HS-0 zero lasts at least 300 ns before toggling
// - trail start to LP-11 start takes at most 105 ns plus 12 UI
// - data lane holds LP-00 for 40 ns + 4 UI to 85 ns + 6 UI
// - data prepare plus HS-0 zero lasts at least 145 ns + 10 UI before sync
// - LP-11 held at least 100 ns after a burst before any new transition
// - trail drives inverse of last bit for max(8 UI, 60 ns + 4 UI)
// - every low-power state in a sequence lasts at least 50 ns; clock lane LP-00 prepare (C_PREP) lasts 40 ns
package dphy_seq_pkg;
    // core clock period and lane unit interval, picoseconds
    localparam int CLK_PS = 40000;
    localparam int nominal_unit_interval = 1670;
    // lane rate window, Mbps and MHz
    localparam int hs_lane_bit_rate_min = 150;
    localparam int hs_lane_bit_rate_max = 600;
    localparam int DDR_CLK_MHZ_MIN = 75;
    localparam int DDR_CLK_MHZ_MAX = 300;
    localparam int hs_lane_bit_rate = 1000000 / nominal_unit_interval;
    localparam bit RATE_OK = (hs_lane_bit_rate >= hs_lane_bit_rate_min) &&
        (hs_lane_bit_rate <= hs_lane_bit_rate_max) &&
        (hs_lane_bit_rate / 2 >= DDR_CLK_MHZ_MIN) && (hs_lane_bit_rate / 2 <= DDR_CLK_MHZ_MAX);
    // line timing, picoseconds
    localparam int T_LPX_MIN = 50000;
    localparam int T_CLK_PRE_MIN = 8000;
    localparam int T_CLK_PREP_MIN = 38000;
    localparam int T_CLK_PREP_MAX = 95000;
    localparam int T_CLK_PZ_MIN = 300000;
    localparam int T_HS_PREP_MIN = 40000 + 4 * nominal_unit_interval;
    localparam int T_HS_PREP_MAX = 85000 + 6 * nominal_unit_interval;
    localparam int T_HS_PZ_MIN = 145000 + 10 * nominal_unit_interval;
    localparam int T_TRAIL_A = 8 * nominal_unit_interval;
    localparam int T_TRAIL_B = 60000 + 4 * nominal_unit_interval;
    localparam int T_TRAIL_MIN = (T_TRAIL_A > T_TRAIL_B) ? T_TRAIL_A : T_TRAIL_B;
    localparam int T_EOT_MAX = 105000 + 12 * nominal_unit_interval;
    localparam int T_EXIT_MIN = 100000;
    // cycle counts: least times round up, longest times round down
    localparam int LPX_CYC = (T_LPX_MIN + CLK_PS - 1) / CLK_PS;
    localparam int CLK_PRE_CYC = (T_CLK_PRE_MIN + CLK_PS - 1) / CLK_PS;
    localparam int CLK_PREP_CYC = (T_CLK_PREP_MIN + CLK_PS - 1) / CLK_PS;
    localparam int CLK_PREP_MAX_CYC = T_CLK_PREP_MAX / CLK_PS;
    localparam int CLK_ZERO_CYC = (T_CLK_PZ_MIN + CLK_PS - 1) / CLK_PS - CLK_PREP_CYC;
    localparam int HS_PREP_CYC = (T_HS_PREP_MIN + CLK_PS - 1) / CLK_PS;
    localparam int HS_PREP_MAX_CYC = T_HS_PREP_MAX / CLK_PS;
    localparam int HS_ZERO_CYC = (T_HS_PZ_MIN + CLK_PS - 1) / CLK_PS - HS_PREP_CYC;
    localparam int TRAIL_CYC = (T_TRAIL_MIN + CLK_PS - 1) / CLK_PS;
    localparam int EOT_MAX_CYC = T_EOT_MAX / CLK_PS;
    localparam int EXIT_CYC = (T_EXIT_MIN + CLK_PS - 1) / CLK_PS;
    // high-speed byte patterns
    localparam logic [7:0] SYNC_BYTE = 8'hb8;
    localparam logic [7:0] CLK_BYTE = 8'haa;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam int LANES = 4;

    typedef enum logic [2:0] {C_OFF, C_STOP, C_REQ, C_PREP, C_ZERO, C_RUN} clk_st_e;
    typedef enum logic [2:0] {D_STOP, D_REQ, D_PREP, D_ZERO, D_SYNC, D_PAY, D_TRAIL} data_st_e;

    // one lane as driven: low-power wire levels, high-speed enable and wire bytes
    typedef struct packed {
        logic lp_p;
        logic lp_n;
        logic hs_en;
        logic [7:0] hs_p;
        logic [7:0] hs_n;
    } lane_s;
    typedef lane_s [LANES-1:0] lanes_t;

    // role-independent drive from the sequencer
    typedef struct packed {
        logic lp_p;
        logic lp_n;
        logic hs_en;
        logic [7:0] hs_byte;
    } role_drive_s;
endpackage : dphy_seq_pkg

/* dphy_tx_sequencer.sv */
/*
 * transmit lane sequencer: clock lane start-up into continuous high speed and data burst sequencing.
 * assumes a 25 MHz core clock; the lane clock arrives unsynchronised and paces payload words.
 */
`timescale 1ns/1ps
module dphy_tx_sequencer (
    input wire logic core_clk_in, // core clock, 25 MHz
    input wire logic rstn_in, // async reset, active low
    input wire logic enable_in, // serial interface enable
    input wire logic [3:0] lane_is_clk_in, // lane role, 1 = clock lane
    input wire logic [3:0] inv_p_in, // invert positive wire per lane
    input wire logic [3:0] inv_n_in, // invert negative wire per lane
    input wire logic ddr_clk_in, // lane clock, sampled
    input wire logic word_valid_in, // payload word offered
    input wire logic [31:0] word_in, // payload word, one byte per data lane
    input wire logic word_last_in, // last word of burst
    output logic word_ready_out, // ready to take a payload word this cycle, taken when word_valid_in is high
    output dphy_seq_pkg::lanes_t lanes_out, // lane drive
    output logic clk_running_out, // clock lane toggling
    output logic burst_active_out // data lanes out of LP-11
);
    typedef struct packed {
        logic [1:0] lck_sync;
        logic lck_prev;
        dphy_seq_pkg::clk_st_e cst;
        logic [3:0] ccnt;
        logic [3:0] pre_cnt;
        dphy_seq_pkg::data_st_e dst;
        logic [3:0] dcnt;
        logic [31:0] word;
        logic last;
        logic run;
        logic busy;
    } seq_state_s;

    seq_state_s st_ff;
    seq_state_s nxt_st;
    logic lck_edge;
    logic take;
    logic pre_ok;
    dphy_seq_pkg::role_drive_s clk_drv;
    dphy_seq_pkg::role_drive_s data_drv;
    logic [31:0] data_word;

    // lane clock edge from the second sync stage only
    assign lck_edge = st_ff.lck_sync[1] & ~st_ff.lck_prev;
    assign word_ready_out = (st_ff.dst == dphy_seq_pkg::D_SYNC || st_ff.dst == dphy_seq_pkg::D_PAY) &&
        lck_edge && !st_ff.last;
    assign take = word_ready_out & word_valid_in;
    assign pre_ok = st_ff.pre_cnt >= 4'(dphy_seq_pkg::CLK_PRE_CYC);

    // next state for both lane sequences
    always_comb begin
        nxt_st = st_ff;
        nxt_st.lck_sync = {st_ff.lck_sync[0], ddr_clk_in};
        nxt_st.lck_prev = st_ff.lck_sync[1];
        nxt_st.ccnt = st_ff.ccnt + 4'h1;
        nxt_st.dcnt = (st_ff.dcnt == 4'hf) ? st_ff.dcnt : st_ff.dcnt + 4'h1;
        // clock lane: once running it never leaves
        case (st_ff.cst)
            dphy_seq_pkg::C_OFF: begin
                nxt_st.ccnt = 4'h0;
                if (enable_in) begin
                    nxt_st.cst = dphy_seq_pkg::C_STOP;
                end
            end
            dphy_seq_pkg::C_STOP: begin
                if (st_ff.ccnt == 4'(dphy_seq_pkg::LPX_CYC - 1)) begin
                    nxt_st.cst = dphy_seq_pkg::C_REQ;
                    nxt_st.ccnt = 4'h0;
                end
            end
            dphy_seq_pkg::C_REQ: begin
                if (st_ff.ccnt == 4'(dphy_seq_pkg::LPX_CYC - 1)) begin
                    nxt_st.cst = dphy_seq_pkg::C_PREP;
                    nxt_st.ccnt = 4'h0;
                end
            end
            dphy_seq_pkg::C_PREP: begin
                if (st_ff.ccnt == 4'(dphy_seq_pkg::CLK_PREP_CYC - 1)) begin
                    nxt_st.cst = dphy_seq_pkg::C_ZERO;
                    nxt_st.ccnt = 4'h0;
                end
            end
            dphy_seq_pkg::C_ZERO: begin
                if (st_ff.ccnt == 4'(dphy_seq_pkg::CLK_ZERO_CYC - 1)) begin
                    nxt_st.cst = dphy_seq_pkg::C_RUN;
                    nxt_st.ccnt = 4'h0;
                end
            end
            dphy_seq_pkg::C_RUN: begin
                nxt_st.ccnt = 4'h0;
            end
            default: begin
                nxt_st.cst = dphy_seq_pkg::C_OFF;
            end
        endcase
        nxt_st.pre_cnt = (st_ff.cst != dphy_seq_pkg::C_RUN) ? 4'h0 :
            (pre_ok ? st_ff.pre_cnt : st_ff.pre_cnt + 4'h1);
        // data lanes
        case (st_ff.dst)
            dphy_seq_pkg::D_STOP: begin
                if (st_ff.dcnt >= 4'(dphy_seq_pkg::EXIT_CYC) && st_ff.dcnt >= 4'(dphy_seq_pkg::LPX_CYC) &&
                    pre_ok && word_valid_in) begin
                    nxt_st.dst = dphy_seq_pkg::D_REQ;
                    nxt_st.dcnt = 4'h0;
                end
            end
            dphy_seq_pkg::D_REQ: begin
                if (st_ff.dcnt == 4'(dphy_seq_pkg::LPX_CYC - 1)) begin
                    nxt_st.dst = dphy_seq_pkg::D_PREP;
                    nxt_st.dcnt = 4'h0;
                end
            end
            dphy_seq_pkg::D_PREP: begin
                if (st_ff.dcnt == 4'(dphy_seq_pkg::HS_PREP_CYC - 1)) begin
                    nxt_st.dst = dphy_seq_pkg::D_ZERO;
                    nxt_st.dcnt = 4'h0;
                end
            end
            dphy_seq_pkg::D_ZERO: begin
                if (st_ff.dcnt == 4'(dphy_seq_pkg::HS_ZERO_CYC - 1)) begin
                    nxt_st.dst = dphy_seq_pkg::D_SYNC;
                    nxt_st.dcnt = 4'h0;
                end
            end
            dphy_seq_pkg::D_SYNC, dphy_seq_pkg::D_PAY: begin
                nxt_st.dcnt = 4'h0;
                if (take) begin
                    nxt_st.dst = dphy_seq_pkg::D_PAY;
                    nxt_st.word = word_in;
                    nxt_st.last = word_last_in;
                end else if (lck_edge && st_ff.dst == dphy_seq_pkg::D_PAY) begin
                    nxt_st.dst = dphy_seq_pkg::D_TRAIL; // last sent or source ran dry
                end
            end
            dphy_seq_pkg::D_TRAIL: begin
                if (st_ff.dcnt == 4'(dphy_seq_pkg::TRAIL_CYC - 1)) begin
                    nxt_st.dst = dphy_seq_pkg::D_STOP;
                    nxt_st.dcnt = 4'h0;
                    nxt_st.last = 1'b0;
                end
            end
            default: begin
                nxt_st.dst = dphy_seq_pkg::D_STOP;
            end
        endcase
        nxt_st.run = nxt_st.cst == dphy_seq_pkg::C_RUN;
        nxt_st.busy = nxt_st.dst != dphy_seq_pkg::D_STOP;
    end

    // single state register
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_ff <= '{lck_sync: 2'h0, lck_prev: 1'b0, cst: dphy_seq_pkg::C_OFF, ccnt: 4'h0, pre_cnt: 4'h0,
                dst: dphy_seq_pkg::D_STOP, dcnt: 4'h0, word: 32'h0, last: 1'b0, run: 1'b0, busy: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // clock lane line state per sequencer state
    always_comb begin
        clk_drv = '{lp_p: 1'b1, lp_n: 1'b1, hs_en: 1'b0, hs_byte: dphy_seq_pkg::ZERO_BYTE};
        case (st_ff.cst)
            dphy_seq_pkg::C_REQ: clk_drv.lp_p = 1'b0;
            dphy_seq_pkg::C_PREP: begin
                clk_drv.lp_p = 1'b0;
                clk_drv.lp_n = 1'b0;
            end
            dphy_seq_pkg::C_ZERO: clk_drv.hs_en = 1'b1;
            dphy_seq_pkg::C_RUN: begin
                clk_drv.hs_en = 1'b1;
                clk_drv.hs_byte = dphy_seq_pkg::CLK_BYTE;
            end
            default: clk_drv.lp_p = 1'b1;
        endcase
    end

    // data lane line state and per-lane byte
    always_comb begin
        data_drv = '{lp_p: 1'b1, lp_n: 1'b1, hs_en: 1'b0, hs_byte: dphy_seq_pkg::ZERO_BYTE};
        data_word = 32'h0;
        case (st_ff.dst)
            dphy_seq_pkg::D_REQ: data_drv.lp_p = 1'b0;
            dphy_seq_pkg::D_PREP: begin
                data_drv.lp_p = 1'b0;
                data_drv.lp_n = 1'b0;
            end
            dphy_seq_pkg::D_ZERO: data_drv.hs_en = 1'b1;
            dphy_seq_pkg::D_SYNC: begin
                data_drv.hs_en = 1'b1;
                data_word = {4{dphy_seq_pkg::SYNC_BYTE}};
            end
            dphy_seq_pkg::D_PAY: begin
                data_drv.hs_en = 1'b1;
                data_word = st_ff.word;
            end
            dphy_seq_pkg::D_TRAIL: begin
                data_drv.hs_en = 1'b1;
                for (int i = 0; i < 4; i++) begin
                    data_word[i*8 +: 8] = {8{~st_ff.word[i*8+7]}};
                end
            end
            default: data_drv.lp_p = 1'b1;
        endcase
    end

    dphy_lane_map u_map (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .lane_is_clk_in(lane_is_clk_in),
        .inv_p_in(inv_p_in),
        .inv_n_in(inv_n_in),
        .clk_drv_in(clk_drv),
        .data_drv_in(data_drv),
        .data_word_in(data_word),
        .lanes_out(lanes_out)
    );

    assign clk_running_out = st_ff.run;
    assign burst_active_out = st_ff.busy;

    // checks
    a_clk_prep_len: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        $rose(st_ff.cst == dphy_seq_pkg::C_PREP) |-> (st_ff.cst == dphy_seq_pkg::C_PREP) [*1] ##1
        (st_ff.cst == dphy_seq_pkg::C_ZERO)) else $error("clock prepare length wrong");
    a_clk_zero_len: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        $rose(st_ff.cst == dphy_seq_pkg::C_PREP) |-> ##8 (st_ff.cst == dphy_seq_pkg::C_RUN) &&
        $past(st_ff.cst) == dphy_seq_pkg::C_ZERO) else $error("clock prepare plus zero too short");
    a_clk_never_lp: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        st_ff.cst == dphy_seq_pkg::C_RUN |=> st_ff.cst == dphy_seq_pkg::C_RUN)
        else $error("clock lane left high speed");
    a_data_prep_len: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        $rose(st_ff.dst == dphy_seq_pkg::D_PREP) |-> (st_ff.dst == dphy_seq_pkg::D_PREP) [*2] ##1
        (st_ff.dst == dphy_seq_pkg::D_ZERO)) else $error("data prepare length wrong");
    a_data_zero_len: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        $rose(st_ff.dst == dphy_seq_pkg::D_PREP) |-> ##5 st_ff.dst == dphy_seq_pkg::D_SYNC)
        else $error("data prepare plus zero too short");
    a_trail_len: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        $rose(st_ff.dst == dphy_seq_pkg::D_TRAIL) |-> (st_ff.dst == dphy_seq_pkg::D_TRAIL) [*2] ##1
        (st_ff.dst == dphy_seq_pkg::D_STOP)) else $error("trail length wrong");
    a_eot_bound: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        $rose(st_ff.dst == dphy_seq_pkg::D_TRAIL) |-> ##[1:3] st_ff.dst == dphy_seq_pkg::D_STOP)
        else $error("end of burst too slow");
    a_exit_hold: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        $fell(st_ff.busy) |-> (st_ff.dst == dphy_seq_pkg::D_STOP) [*3])
        else $error("stop state after burst too short");
    a_req_lpx: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        $rose(st_ff.dst == dphy_seq_pkg::D_REQ) |-> (st_ff.dst == dphy_seq_pkg::D_REQ) [*2])
        else $error("request state shorter than low-power minimum");
    a_clk_pre_data: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        $rose(st_ff.dst == dphy_seq_pkg::D_REQ) |-> $past(st_ff.cst) == dphy_seq_pkg::C_RUN &&
        $past(st_ff.pre_cnt) >= 4'h1) else $error("data entry before clock ran");
    a_burst_order: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        $rose(st_ff.dst == dphy_seq_pkg::D_PAY) |-> $past(st_ff.dst) == dphy_seq_pkg::D_SYNC)
        else $error("payload without sync");
endmodule : dphy_tx_sequencer

/* testbench.sv */
/*
 * bench for the lane sequencer: clock start-up, bursts, lane roles and polarity.
 * assumes the receiver model beside it; lane clock free running at 320 ns.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module testbench;
    localparam int CK = 40000;
    localparam int UI = dphy_seq_pkg::nominal_unit_interval;
    logic core_clk_in = 1'b0;
    logic ddr_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic enable_in = 1'b0;
    logic [3:0] lane_is_clk_in = 4'h8;
    logic [3:0] inv_p_in = 4'h0;
    logic [3:0] inv_n_in = 4'h0;
    logic word_valid_in = 1'b0;
    logic [31:0] word_in = 32'h0;
    logic word_last_in = 1'b0;
    logic word_ready_out;
    logic clk_running_out;
    logic burst_active_out;
    dphy_seq_pkg::lanes_t lanes_out;
    logic [7:0] bursts;
    logic [7:0] first_byte;
    logic clk_drop;
    logic [31:0] words [0:1];
    int nw, idx, errors, num_checks, cyc, a, b, c, n;

    dphy_tx_sequencer u_dphy_tx_sequencer (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
        .enable_in(enable_in), .lane_is_clk_in(lane_is_clk_in), .inv_p_in(inv_p_in), .inv_n_in(inv_n_in),
        .ddr_clk_in(ddr_clk_in), .word_valid_in(word_valid_in), .word_in(word_in), .word_last_in(word_last_in),
        .word_ready_out(word_ready_out), .lanes_out(lanes_out), .clk_running_out(clk_running_out),
        .burst_active_out(burst_active_out));
    dphy_rx_model u_dphy_rx_model (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .lanes_in(lanes_out),
        .lane_is_clk_in(lane_is_clk_in), .inv_p_in(inv_p_in), .bursts_out(bursts),
        .first_byte_out(first_byte), .clk_drop_out(clk_drop));

    // core clock and an unaligned lane clock
    always #20 core_clk_in = ~core_clk_in;
    initial begin
        #7;
        forever #160 ddr_clk_in = ~ddr_clk_in;
    end

    // hands over the next word on each take
    always @(posedge core_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            errors++;
            stop_test();
        end
        if (word_ready_out && word_valid_in) begin
            idx <= idx + 1;
            word_in <= words[(idx + 1) % 2];
            word_last_in <= (idx + 2 == nw);
            if (idx + 1 == nw) word_valid_in <= 1'b0;
        end
    end

    // line state code: lp pair, or 4 zero, 5 sync, 7 all ones, 6 other byte
    function automatic int st(input dphy_seq_pkg::lane_s l);
        if (!l.hs_en) return int'({l.lp_p, l.lp_n});
        case (l.hs_p)
            8'h00: return 4;
            8'hb8: return 5;
            8'hff: return 7;
            default: return 6;
        endcase
    endfunction : st

    task automatic send(input int cnt);
        @(posedge core_clk_in);
        idx <= 0;
        nw <= cnt;
        word_in <= words[0];
        word_last_in <= (cnt == 1);
        word_valid_in <= 1'b1;
    endtask : send

    task automatic wait_lane(input int k, input int code);
        for (int i = 0; i < 400 && st(lanes_out[k]) != code; i++) begin
            @(posedge core_clk_in);
            #1;
        end
        `CHK("wait state", code, st(lanes_out[k]))
    endtask : wait_lane

    // checks the present state, then counts the cycles it stands
    task automatic seg(input int k, input int code, output int len);
        `CHK("lane state", code, st(lanes_out[k]))
        len = 0;
        while (st(lanes_out[k]) == code && len < 400) begin
            @(posedge core_clk_in);
            #1;
            len++;
        end
    endtask : seg

    task automatic stop_test;
        if (errors == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : stop_test

    // main sequence
    initial begin
        words[0] = 32'h0033_2211;
        words[1] = 32'h0081_0201;
        repeat (6) @(posedge core_clk_in);
        #1;
        `CHK("idle state", 3, st(lanes_out[0]))
        `CHK("running", 1'b0, clk_running_out)
        @(posedge core_clk_in);
        rstn_in <= 1'b1;
        enable_in <= 1'b1;
        #1;
        wait_lane(3, 1);
        seg(3, 1, a);
        `CHK("clk lp01", 1'b1, a * CK >= 50000)
        seg(3, 0, b);
        `CHK("clk prep", 1'b1, b * CK >= 38000 && b * CK <= 95000)
        seg(3, 4, c);
        `CHK("clk zero", 1'b1, (b + c) * CK >= 300000)
        `CHK("clk byte", 8'haa, lanes_out[3].hs_p)
        send(2);
        enable_in <= 1'b0;
        #1;
        wait_lane(0, 1);
        `CHK("clk first", 6, st(lanes_out[3]))
        `CHK("busy", 1'b1, burst_active_out)
        seg(0, 1, a);
        `CHK("lp01", 1'b1, a * CK >= 50000)
        seg(0, 0, b);
        `CHK("prep", 1'b1, b * CK >= 40000 + 4 * UI && b * CK <= 85000 + 6 * UI)
        seg(0, 4, c);
        `CHK("zero", 1'b1, (b + c) * CK >= 145000 + 10 * UI)
        seg(0, 5, n);
        seg(0, 6, n);
        `CHK("trail lane2", 8'h00, lanes_out[2].hs_p)
        seg(0, 7, a);
        `CHK("trail len", 1'b1, a * CK >= 60000 + 4 * UI && a * CK >= 8 * UI)
        `CHK("eot", 1'b1, a * CK <= 105000 + 12 * UI)
        send(2);
        #1;
        seg(0, 3, n);
        `CHK("exit", 1'b1, (n + 1) * CK >= 100000)
        wait_lane(0, 7);
        wait_lane(0, 3);
        `CHK("bursts", 8'h02, bursts)
        `CHK("first byte", 8'h11, first_byte)
        `CHK("clk drop", 1'b0, clk_drop)
        `CHK("running", 1'b1, clk_running_out)
        `CHK("idle busy", 1'b0, burst_active_out)
        @(posedge core_clk_in);
        inv_p_in <= 4'h9;
        inv_n_in <= 4'h8;
        repeat (3) @(posedge core_clk_in);
        #1;
        `CHK("inv lp", 2'b01, {lanes_out[0].lp_p, lanes_out[0].lp_n})
        `CHK("inv hs p", 8'h55, lanes_out[3].hs_p)
        `CHK("inv hs n", 8'haa, lanes_out[3].hs_n)
        @(posedge core_clk_in);
        rstn_in <= 1'b0;
        enable_in <= 1'b0;
        inv_p_in <= 4'h0;
        inv_n_in <= 4'h0;
        lane_is_clk_in <= 4'h1;
        repeat (6) @(posedge core_clk_in);
        `CHK("reset running", 1'b0, clk_running_out)
        `CHK("reset busy", 1'b0, burst_active_out)
        rstn_in <= 1'b1;
        enable_in <= 1'b1;
        #1;
        wait_lane(0, 6);
        `CHK("role clk", 8'haa, lanes_out[0].hs_p)
        words[0] = 32'h0000_0044;
        send(1);
        #1;
        wait_lane(1, 7);
        wait_lane(1, 3);
        `CHK("role data", 8'h44, first_byte)
        `CHK("role clk drop", 1'b0, clk_drop)
        `CHK("rate", 1'b1, 1000000 / UI >= 150 && 1000000 / UI <= 600)
        stop_test();
    end
endmodule : testbench
